// ---- pkg/lts_pkg.sv ----
/*
 * lts_pkg: shared constants and types of the line trigger and strobe control
 * block: register map, field codes, limits, reset values and timing counts.
 * Assumes a 100 MHz aclk; all time registers are held in units derived here.
 */
`default_nettype none

package lts_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and time units
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned US_NS         = 1000;
	localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
	// fractional microsecond registers count hundredths of a microsecond
	localparam int unsigned CENTI_US_NS   = 10;
	localparam int unsigned CYC_PER_CENTI = CENTI_US_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LPER = 8'h04;
	localparam logic [7:0] ADDR_EXPO = 8'h08;
	localparam logic [7:0] ADDR_RATE = 8'h0C;
	localparam logic [7:0] ADDR_SDLY = 8'h10;
	localparam logic [7:0] ADDR_SDUR = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// control word, bit 0 upward: stages, flip, area, inv, strobe mode,
	// filter, rescaler, activation, source, trigger on
	typedef struct packed {
		logic       trig_on;    // bit 16
		logic [2:0] src;        // bits 15:13
		logic [1:0] act;        // bits 12:11
		logic       resc_en;    // bit 10
		logic [2:0] filt;       // bits 9:7
		logic [1:0] strb_mode;  // bits 6:5
		logic       strb_inv;   // bit 4
		logic       area;       // bit 3
		logic       flip;       // bit 2
		logic [1:0] stages;     // bits 1:0, code minus one
	} lts_cfg_type;
	localparam int unsigned CFG_W = $bits(lts_cfg_type);

	localparam logic [2:0] SRC_CC1    = 3'h1;
	localparam logic [2:0] SRC_EXT    = 3'h5;
	localparam logic [1:0] ACT_RISE   = 2'h0;
	localparam logic [1:0] ACT_FALL   = 2'h1;
	localparam logic [1:0] ACT_BOTH   = 2'h2;
	localparam logic [1:0] SM_OFF     = 2'h0;
	localparam logic [1:0] SM_PULSE   = 2'h1;
	localparam logic [1:0] SM_FOLLOW  = 2'h2;
	localparam logic [2:0] FILT_MAX   = 3'h5;
	localparam logic [9:0] FILT_BASE  = 10'h010;

	////////////////////////////////////////////////////////////////////////////
	// limits and reset values
	localparam logic [31:0] RATE_SCALE = 32'h0000_03E8; // rate counts thousandths
	localparam logic [31:0] RATE_MIN   = 32'h0000_000A; // 0.010
	localparam logic [31:0] RATE_MAX   = 32'h0001_86A0; // 100.000
	localparam logic [31:0] SDLY_MAX   = 32'h0001_86A0; // 1000.00 us
	localparam logic [31:0] SDUR_MIN   = 32'h0000_0064; // 1.00 us
	localparam logic [31:0] SDUR_MAX   = 32'h0001_86A0; // 1000.00 us
	localparam logic [31:0] EXPO_MAX   = 32'h000F_FFFF;

	localparam lts_cfg_type CFG_RST = '{trig_on: 1'b0, src: SRC_CC1, act: ACT_RISE,
		resc_en: 1'b0, filt: 3'h0, strb_mode: SM_OFF, strb_inv: 1'b0, area: 1'b0,
		flip: 1'b0, stages: 2'h3};
	localparam logic [31:0] LPER_RST = 32'h0000_0B29; // 28.57 us, about 35 kHz
	localparam logic [31:0] EXPO_RST = 32'h0000_000A;
	localparam logic [31:0] RATE_RST = 32'h0000_03E8;
	localparam logic [31:0] SDLY_RST = 32'h0000_0000;
	localparam logic [31:0] SDUR_RST = 32'h0000_0064;

	// strobe sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DLY  = 3'b010,
		ST_ACT  = 3'b100
	} lts_strobe_type;

endpackage

`default_nettype wire

// ---- rtl/lts_trig_filter.sv ----
/*
 * lts_trig_filter: synchronises both trigger pins, picks one, rejects pulses
 * shorter than the selected noise filter length and flags its edges.
 * Assumes the pins are asynchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module lts_trig_filter (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// raw pins, bit 0 frame grabber line, bit 1 external line
	input  wire logic [1:0] pins_raw,
	// settings
	input  wire logic       sel_ext,
	input  wire logic       filt_on,
	input  wire logic [2:0] filt_code,
	// filtered level and its edges
	output logic            level,
	output logic            rise,
	output logic            fall
);

	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] s3_r;
	logic       lvl_r;
	logic       lvl_nxt;
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       rise_nxt;
	logic       fall_nxt;
	logic [9:0] len;
	logic       pick;
	logic       agree;

	////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= pins_raw[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		pick     = sel_ext ? s3_r[1] : s3_r[0];
		agree    = sel_ext ? (s2_r[1] == s3_r[1]) : (s2_r[0] == s3_r[0]);
		len      = filt_on ? 10'(lts_pkg::FILT_BASE << filt_code) : 10'h001;
		lvl_nxt  = lvl_r;
		cnt_nxt  = 10'h000;
		if (agree && (pick != lvl_r)) begin
			if (cnt_r >= len - 10'h001) begin
				lvl_nxt = pick;
			end else begin
				cnt_nxt = cnt_r + 10'h001;
			end
		end
		rise_nxt = lvl_nxt && !lvl_r;
		fall_nxt = !lvl_nxt && lvl_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_r <= 1'b0;
			cnt_r <= 10'h000;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			lvl_r <= lvl_nxt;
			cnt_r <= cnt_nxt;
			rise  <= rise_nxt;
			fall  <= fall_nxt;
		end
	end

	assign level = lvl_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_filter_len: assert property (
		(lvl_r != $past(lvl_r)) |-> ($past(cnt_r) == $past(len) - 10'h001))
		else $error("filtered level changed before filter length elapsed");

endmodule

`default_nettype wire

// ---- rtl/lts_ctrl.sv ----
/*
 * lts_ctrl: line start, exposure, stage and strobe control of a line-scan
 * camera, configured over AXI4-Lite.
 * Assumes one 100 MHz clock, synchronous active-low reset, and trigger pins
 * that are asynchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none

module lts_ctrl #(
	parameter int unsigned ADDR_W     = 8,
	parameter int unsigned STAGE_BASE = 16
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// trigger pins and strobe pin
	input  wire logic              cc1_in,
	input  wire logic              ext_trig_in,
	output logic                   strobe_out,
	// sensor timing
	output logic                   line_start,
	output logic                   exposure_on,
	output logic [8:0]             stage_count,
	output logic                   flip_x,
	output logic                   area_mode
);

	lts_pkg::lts_cfg_type cfg_r, cfg_nxt, cfg_w;
	logic [31:0] lper_r, lper_nxt, expo_r, expo_nxt, rate_r, rate_nxt;
	logic [31:0] sdly_r, sdly_nxt, sdur_r, sdur_nxt;
	logic [7:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, wv;
	logic [3:0]  w_strb_r, w_strb_nxt;
	logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic [15:0] line_cnt_r, line_cnt_nxt;

	////////////////////////////////////////////////////////////////////////////
	// register file

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		case (a)
			lts_pkg::ADDR_CTRL: rd_word = 32'(cfg_r);
			lts_pkg::ADDR_LPER: rd_word = lper_r;
			lts_pkg::ADDR_EXPO: rd_word = expo_r;
			lts_pkg::ADDR_RATE: rd_word = rate_r;
			lts_pkg::ADDR_SDLY: rd_word = sdly_r;
			lts_pkg::ADDR_SDUR: rd_word = sdur_r;
			lts_pkg::ADDR_STAT: rd_word = {line_cnt_r, 7'h00, stage_count};
			default:            rd_word = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= lts_pkg::ADDR_STAT);
	endfunction

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		aw_addr_nxt = aw_addr_r;
		w_hold_nxt  = w_hold_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		bvalid_nxt  = s_axi_bvalid;
		bresp_nxt   = s_axi_bresp;
		rvalid_nxt  = s_axi_rvalid;
		rresp_nxt   = s_axi_rresp;
		rdata_nxt   = s_axi_rdata;
		cfg_nxt     = cfg_r;
		lper_nxt    = lper_r;
		expo_nxt    = expo_r;
		rate_nxt    = rate_r;
		sdly_nxt    = sdly_r;
		sdur_nxt    = sdur_r;
		wv          = 32'h0000_0000;
		cfg_w       = cfg_r;
		if (s_axi_bvalid && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			aw_addr_nxt = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = lts_pkg::RESP_OKAY;
			wv          = rd_word(aw_addr_r);
			for (int i = 0; i < 4; i++)
				if (w_strb_r[i])
					wv[i*8 +: 8] = w_data_r[i*8 +: 8];
			cfg_w = lts_pkg::lts_cfg_type'(wv[lts_pkg::CFG_W-1:0]);
			// out-of-range values are refused and the old value kept
			case (aw_addr_r)
				lts_pkg::ADDR_CTRL:
					if ((cfg_w.src == lts_pkg::SRC_CC1 || cfg_w.src == lts_pkg::SRC_EXT)
					    && cfg_w.act != 2'h3 && cfg_w.filt <= lts_pkg::FILT_MAX
					    && cfg_w.strb_mode != 2'h3 && wv[31:lts_pkg::CFG_W] == '0)
						cfg_nxt = cfg_w;
					else
						bresp_nxt = lts_pkg::RESP_SLVERR;
				lts_pkg::ADDR_LPER:
					if (wv != 32'h0000_0000) lper_nxt = wv;
					else bresp_nxt = lts_pkg::RESP_SLVERR;
				lts_pkg::ADDR_EXPO:
					if (wv <= lts_pkg::EXPO_MAX) expo_nxt = wv;
					else bresp_nxt = lts_pkg::RESP_SLVERR;
				lts_pkg::ADDR_RATE:
					if (wv >= lts_pkg::RATE_MIN && wv <= lts_pkg::RATE_MAX)
						rate_nxt = wv;
					else
						bresp_nxt = lts_pkg::RESP_SLVERR;
				lts_pkg::ADDR_SDLY:
					if (wv <= lts_pkg::SDLY_MAX) sdly_nxt = wv;
					else bresp_nxt = lts_pkg::RESP_SLVERR;
				lts_pkg::ADDR_SDUR:
					if (wv >= lts_pkg::SDUR_MIN && wv <= lts_pkg::SDUR_MAX)
						sdur_nxt = wv;
					else
						bresp_nxt = lts_pkg::RESP_SLVERR;
				default: bresp_nxt = lts_pkg::RESP_SLVERR;
			endcase
		end
		awready_nxt = !aw_hold_nxt;
		wready_nxt  = !w_hold_nxt;
		if (s_axi_rvalid && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_word(8'(s_axi_araddr));
			rresp_nxt  = mapped(8'(s_axi_araddr)) ? lts_pkg::RESP_OKAY : lts_pkg::RESP_SLVERR;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r     <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_hold_r      <= 1'b0;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= lts_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= lts_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			cfg_r         <= lts_pkg::CFG_RST;
			lper_r        <= lts_pkg::LPER_RST;
			expo_r        <= lts_pkg::EXPO_RST;
			rate_r        <= lts_pkg::RATE_RST;
			sdly_r        <= lts_pkg::SDLY_RST;
			sdur_r        <= lts_pkg::SDUR_RST;
		end else begin
			aw_hold_r     <= aw_hold_nxt;
			aw_addr_r     <= aw_addr_nxt;
			w_hold_r      <= w_hold_nxt;
			w_data_r      <= w_data_nxt;
			w_strb_r      <= w_strb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rdata   <= rdata_nxt;
			cfg_r         <= cfg_nxt;
			lper_r        <= lper_nxt;
			expo_r        <= expo_nxt;
			rate_r        <= rate_nxt;
			sdly_r        <= sdly_nxt;
			sdur_r        <= sdur_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trigger input, line pacing, rescaler, exposure

	logic        trig_lvl, trig_rise, trig_fall, acc_evt;
	logic [31:0] lp_cnt_r, lp_cnt_nxt, per_cnt_r, per_cnt_nxt, in_per_r, in_per_nxt;
	logic [47:0] acc_r, acc_nxt, thr, acc_sum;
	logic [39:0] exp_cnt_r, exp_cnt_nxt;
	logic        line_nxt, exp_nxt;

	lts_trig_filter u_filt (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pins_raw  ({ext_trig_in, cc1_in}),
		.sel_ext   (cfg_r.src == lts_pkg::SRC_EXT),
		.filt_on   (cfg_r.resc_en),
		.filt_code (cfg_r.filt),
		.level     (trig_lvl),
		.rise      (trig_rise),
		.fall      (trig_fall)
	);

	always_comb begin
		case (cfg_r.act)
			lts_pkg::ACT_RISE: acc_evt = trig_rise;
			lts_pkg::ACT_FALL: acc_evt = trig_fall;
			lts_pkg::ACT_BOTH: acc_evt = trig_rise || trig_fall;
			default:           acc_evt = 1'b0;
		endcase
		acc_evt      = acc_evt && cfg_r.trig_on;
		line_nxt     = 1'b0;
		lp_cnt_nxt   = 32'h0000_0000;
		per_cnt_nxt  = (per_cnt_r == 32'hFFFF_FFFF) ? per_cnt_r : per_cnt_r + 32'h1;
		in_per_nxt   = in_per_r;
		thr          = 48'(in_per_r) * 48'(lts_pkg::RATE_SCALE);
		acc_sum      = acc_r + 48'(rate_r);
		acc_nxt      = 48'h0;
		if (!cfg_r.trig_on) begin
			if (lp_cnt_r >= lper_r - 32'h1)
				line_nxt = 1'b1;
			else
				lp_cnt_nxt = lp_cnt_r + 32'h1;
		end else if (!cfg_r.resc_en) begin
			line_nxt = acc_evt;
		end else begin
			// input period measured between accepted edges; fractional
			// multiplier by phase accumulation, no divider needed
			if (acc_evt) begin
				in_per_nxt  = per_cnt_r + 32'h1;
				per_cnt_nxt = 32'h0000_0000;
			end
			if (in_per_r != 32'h0000_0000) begin
				acc_nxt = acc_sum;
				if (acc_sum >= thr) begin
					line_nxt = 1'b1;
					acc_nxt  = acc_sum - thr;
				end
			end
		end
		line_cnt_nxt = line_cnt_r + (line_nxt ? 16'h0001 : 16'h0000);
		exp_nxt      = 1'b0;
		exp_cnt_nxt  = 40'h0;
		if (cfg_r.area) begin
			if (line_nxt && expo_r != 32'h0000_0000) begin
				exp_nxt     = 1'b1;
				exp_cnt_nxt = 40'(expo_r) * 40'(lts_pkg::CYC_PER_US) - 40'h1;
			end else if (exp_cnt_r != 40'h0) begin
				exp_nxt     = 1'b1;
				exp_cnt_nxt = exp_cnt_r - 40'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_cnt_r    <= 32'h0000_0000;
			per_cnt_r   <= 32'h0000_0000;
			in_per_r    <= 32'h0000_0000;
			acc_r       <= 48'h0;
			exp_cnt_r   <= 40'h0;
			line_start  <= 1'b0;
			exposure_on <= 1'b0;
			line_cnt_r  <= 16'h0000;
			stage_count <= 9'h000;
			flip_x      <= 1'b0;
			area_mode   <= 1'b0;
		end else begin
			lp_cnt_r    <= lp_cnt_nxt;
			per_cnt_r   <= per_cnt_nxt;
			in_per_r    <= in_per_nxt;
			acc_r       <= acc_nxt;
			exp_cnt_r   <= exp_cnt_nxt;
			line_start  <= line_nxt;
			exposure_on <= exp_nxt;
			line_cnt_r  <= line_cnt_nxt;
			stage_count <= 9'((cfg_r.stages + 2'h1) * STAGE_BASE);
			flip_x      <= cfg_r.flip;
			area_mode   <= cfg_r.area;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// strobe sequencer

	lts_pkg::lts_strobe_type st_r, st_nxt;
	logic [31:0] st_cnt_r, st_cnt_nxt;
	logic        strb_evt, strb_lvl;

	always_comb begin
		strb_evt   = cfg_r.trig_on ? acc_evt : line_nxt;
		st_nxt     = st_r;
		st_cnt_nxt = st_cnt_r;
		case (st_r)
			lts_pkg::ST_IDLE:
				if (strb_evt && cfg_r.strb_mode == lts_pkg::SM_PULSE) begin
					st_nxt     = (sdly_r == 32'h0) ? lts_pkg::ST_ACT : lts_pkg::ST_DLY;
					st_cnt_nxt = (sdly_r == 32'h0) ? sdur_r - 32'h1 : sdly_r - 32'h1;
				end
			lts_pkg::ST_DLY:
				if (st_cnt_r == 32'h0) begin
					st_nxt     = lts_pkg::ST_ACT;
					st_cnt_nxt = sdur_r - 32'h1;
				end else begin
					st_cnt_nxt = st_cnt_r - 32'h1;
				end
			lts_pkg::ST_ACT:
				if (st_cnt_r == 32'h0)
					st_nxt = lts_pkg::ST_IDLE;
				else
					st_cnt_nxt = st_cnt_r - 32'h1;
			default: st_nxt = lts_pkg::ST_IDLE;
		endcase
		// a mode change mid-pulse abandons the pulse
		if (cfg_r.strb_mode != lts_pkg::SM_PULSE)
			st_nxt = lts_pkg::ST_IDLE;
		case (cfg_r.strb_mode)
			lts_pkg::SM_PULSE:  strb_lvl = (st_r == lts_pkg::ST_ACT);
			lts_pkg::SM_FOLLOW: strb_lvl = cfg_r.trig_on && trig_lvl;
			default:            strb_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r       <= lts_pkg::ST_IDLE;
			st_cnt_r   <= 32'h0000_0000;
			strobe_out <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			st_cnt_r   <= st_cnt_nxt;
			strobe_out <= strb_lvl ^ cfg_r.strb_inv;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_free_pace: assert property (
		(!cfg_r.trig_on && lp_cnt_r >= lper_r - 32'h1) |=> line_start)
		else $error("free-run line start missing at period end");
	chk_free_ignores: assert property (
		(!cfg_r.trig_on && lp_cnt_r < lper_r - 32'h1) |=> !line_start)
		else $error("free-run line start before period end");
	chk_trig_bypass: assert property (
		(cfg_r.trig_on && !cfg_r.resc_en) |=> (line_start == $past(acc_evt)))
		else $error("bypassed trigger did not map one to one onto line start");
	chk_edge_select: assert property (
		(cfg_r.trig_on && acc_evt) |-> ((cfg_r.act == lts_pkg::ACT_RISE && trig_rise)
			|| (cfg_r.act == lts_pkg::ACT_FALL && trig_fall)
			|| (cfg_r.act == lts_pkg::ACT_BOTH)))
		else $error("trigger accepted on wrong edge");
	chk_rate_range: assert property (
		(aw_hold_r && w_hold_r && !s_axi_bvalid && aw_addr_r == lts_pkg::ADDR_RATE
			&& w_strb_r == 4'hF && (w_data_r < lts_pkg::RATE_MIN
			|| w_data_r > lts_pkg::RATE_MAX))
		|=> (s_axi_bvalid && s_axi_bresp == lts_pkg::RESP_SLVERR && $stable(rate_r)))
		else $error("out of range rescaler rate was not refused");
	chk_strobe_off: assert property (
		(cfg_r.strb_mode == lts_pkg::SM_OFF) |=> (strobe_out == $past(cfg_r.strb_inv)))
		else $error("strobe active while strobe mode is off");
	chk_pulse_polar: assert property (
		(cfg_r.strb_mode == lts_pkg::SM_PULSE && st_r == lts_pkg::ST_ACT)
		|=> (strobe_out != $past(cfg_r.strb_inv)))
		else $error("strobe pulse has wrong polarity");
	chk_delay_end: assert property (
		(st_r == lts_pkg::ST_DLY && st_cnt_r == 32'h0
			&& cfg_r.strb_mode == lts_pkg::SM_PULSE)
		|=> (st_r == lts_pkg::ST_ACT && st_cnt_r == $past(sdur_r) - 32'h1))
		else $error("strobe did not start full duration after delay");
	chk_area_only: assert property (
		!cfg_r.area |=> !exposure_on)
		else $error("exposure active outside area mode");
	chk_resc_fire: assert property (
		(cfg_r.trig_on && cfg_r.resc_en && in_per_r != 32'h0 && acc_sum >= thr)
		|=> line_start)
		else $error("rescaler missed a line start");

	cov_free_line:  cover property (!cfg_r.trig_on && line_start);
	cov_resc_line:  cover property (cfg_r.trig_on && cfg_r.resc_en && line_start);
	cov_pulse_done: cover property (st_r == lts_pkg::ST_ACT ##1 st_r == lts_pkg::ST_IDLE);
	cov_area_exp:   cover property (cfg_r.area && exposure_on);

endmodule

`default_nettype wire

// ---- testbench/lts_trig_src.sv ----
/*
 * lts_trig_src: frame grabber and external trigger line model.
 * Assumes the bench calls pulses() just after a rising edge of aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module lts_trig_src (
	// clock
	input  wire logic aclk,
	// trigger lines, both idle low
	output logic      cc1_in,
	output logic      ext_trig_in
);
	initial begin
		cc1_in = 1'b0;
		ext_trig_in = 1'b0;
	end

	// w must stay above the noise filter length or pulses vanish
	task automatic pulses(input logic ext, input int n, input int w);
		for (int i = 0; i < n; i++) begin
			{ext_trig_in, cc1_in} <= ext ? 2'b10 : 2'b01;
			repeat (w) @(posedge aclk);
			{ext_trig_in, cc1_in} <= 2'b00;
			repeat (w) @(posedge aclk);
		end
	endtask
endmodule

`default_nettype wire

// ---- testbench/lts_ctrl_tb.sv ----
/*
 * lts_ctrl_tb: register, line start and strobe checks of lts_ctrl.
 * Assumes a 100 MHz aclk and the trigger model in lts_trig_src.
 */
`timescale 1ns/1ps
`default_nettype none

module lts_ctrl_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, cc1_in, ext_trig_in, strobe_out;
	logic        line_start, exposure_on, flip_x, area_mode, sprev;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [8:0]  stage_count;
	int          miscompares, comparisons, lines, strb, n0, s0, exps, e0, lag, dly;
	logic [7:0]  ra [5] = '{lts_pkg::ADDR_RATE, lts_pkg::ADDR_RATE, lts_pkg::ADDR_SDLY,
		lts_pkg::ADDR_SDUR, 8'h1C};
	logic [31:0] rv [5] = '{lts_pkg::RATE_MIN - 32'h1, lts_pkg::RATE_MAX + 32'h1,
		lts_pkg::SDLY_MAX + 32'h1, lts_pkg::SDUR_MIN - 32'h1, 32'h0};
	logic [2:0]  tsrc [5] = '{3'h1, 3'h1, 3'h1, 3'h5, 3'h5};
	logic        tpin [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [1:0]  tact [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
	int          tn [5] = '{4, 4, 8, 0, 4};

	lts_ctrl i_lts_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc1_in, .ext_trig_in,
		.strobe_out, .line_start, .exposure_on, .stage_count, .flip_x, .area_mode);
	lts_trig_src i_lts_trig_src (.aclk, .cc1_in, .ext_trig_in);

	always #5 aclk = ~aclk;
	// counted on the falling edge, so snapshots taken at rising edges never race
	always @(negedge aclk) begin
		if (line_start === 1'b1) lines++;
		if (strobe_out === 1'b1) strb++;
		if (exposure_on === 1'b1) exps++;
		lag = (line_start === 1'b1) ? 0 : lag + 1;
		if (strobe_out === 1'b1 && sprev === 1'b0) dly = lag;
		sprev = strobe_out;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		{aw, w} = 2'b11;
		while (aw || w) begin
			@(posedge aclk);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, 32'h0);
		s_axi_rready <= 1'b0;
	endtask

	// control word: on, source, activation, strobe mode, fl = invert, area, flip, stages
	function automatic logic [31:0] cfg(input logic on, input logic [2:0] sr,
		input logic [1:0] ac, input logic [1:0] sm, input logic [4:0] fl);
		return {15'h0, on, sr, ac, 4'h0, sm, fl};
	endfunction

	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#500us;
		miscompares++;
		report_and_stop;
	end

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(lts_pkg::ADDR_CTRL, 32'h0000_2003);
		rd(lts_pkg::ADDR_LPER, lts_pkg::LPER_RST);
		chk({23'h0, stage_count}, 32'h40);
		wr(lts_pkg::ADDR_CTRL, cfg(0, 3'h1, 2'h0, 2'h0, 5'h1C), 2'h0);
		repeat (3) @(posedge aclk);
		chk({23'h0, stage_count}, 32'h10);
		chk({29'h0, flip_x, area_mode, strobe_out}, 32'h7);
		for (int i = 0; i < 5; i++) wr(ra[i], rv[i], lts_pkg::RESP_SLVERR);
		rd(lts_pkg::ADDR_RATE, lts_pkg::RATE_RST);
		// free run in area mode: period 200, exposure 100, strobe 100 after 50
		wr(lts_pkg::ADDR_CTRL, cfg(0, 3'h1, 2'h0, lts_pkg::SM_PULSE, 5'h0B), 2'h0);
		wr(lts_pkg::ADDR_LPER, 32'h0000_00C8, 2'h0);
		wr(lts_pkg::ADDR_EXPO, 32'h0000_0001, 2'h0);
		wr(lts_pkg::ADDR_SDLY, 32'h0000_0032, 2'h0);
		repeat (3000) @(posedge aclk);
		{n0, s0, e0} = {lines, strb, exps};
		repeat (2000) @(posedge aclk);
		chk(lines - n0, 10);
		chk(strb - s0, 1000);
		chk(exps - e0, 1000);
		// strobe pin rises delay plus one registered cycle after line_start
		chk(dly, 51);
		for (int i = 0; i < 5; i++) begin
			wr(lts_pkg::ADDR_CTRL, cfg(1, tsrc[i], tact[i], lts_pkg::SM_FOLLOW, 5'h03), 2'h0);
			repeat (50) @(posedge aclk);
			{n0, s0} = {lines, strb};
			i_lts_trig_src.pulses(tpin[i], 4, 20);
			repeat (30) @(posedge aclk);
			chk(lines - n0, tn[i]);
			chk(strb - s0, (tn[i] != 0) ? 80 : 0);
		end
		// rescaler on (bit 10), filter 16: input period 80 at rate 2.000 gives one line per 40
		wr(lts_pkg::ADDR_RATE, 32'h0000_07D0, 2'h0);
		wr(lts_pkg::ADDR_CTRL, cfg(1, 3'h1, 2'h0, 2'h0, 5'h03) | 32'h0000_0400, 2'h0);
		i_lts_trig_src.pulses(1'b0, 6, 40);
		n0 = lines;
		i_lts_trig_src.pulses(1'b0, 4, 40);
		chk(lines - n0, 8);
		report_and_stop;
	end
endmodule

`default_nettype wire
